// File: hw/relay_ctl_defines.svh
// Purpose: register offsets, field positions and timing figures of the relay control block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: definitions only
`ifndef RELAY_CTL_DEFINES_SVH
`define RELAY_CTL_DEFINES_SVH

`define ADDR_W 8
`define A_BANK 8'h00
`define A_SWAP 8'h04
`define A_EXT_CFG 8'h08
`define A_SER_RESET 8'h0C
`define A_INT_MASK 8'h10
`define A_INT_EDGE 8'h14
`define A_CTL_MASK 8'h18
`define A_CTL_EDGE 8'h1C
`define A_POST 8'h20
`define A_STATUS 8'h24
`define A_UPLOAD 8'h28
`define A_SET_MAIN 8'h2C
`define A_SET_SECOND 8'h30

`define F_ROUTE_IND 2:0
`define F_ROUTE_OUT 5:3
`define F_ROUTE_ALL 8:6
`define F_ROUTE_BANK 11:9
`define F_SER_PARTIAL 0
`define F_SER_FULL 1

`define CLK_HZ 100000000
`define RATED_HZ 50
`define SAMPLES_PER_CYCLE 40
`define REC_CYCLES 38
`define REC_DEPTH (`REC_CYCLES * `SAMPLES_PER_CYCLE)
`define PTR_W 11
`define ADC_W 12
`define SET_W 16
`define DIV_W 16
`define POST_W 6
`define POSTCNT_W 12
`define WORDS_PER_SAMPLE 2'h3
`define BANK_MAIN 1'b0
`define BANK_SECOND 1'b1

`endif

// File: hw/relay_ctl_pkg.sv
// Purpose: types shared by the relay control block
// Assumes: constants come from relay_ctl_defines.svh
// Notes: none
`include "relay_ctl_defines.svh"
package relay_ctl_pkg;

	typedef enum logic [1:0] {REC_ARMED, REC_POST, REC_FULL} rec_e;

	typedef struct packed {
		logic [5:0][`ADC_W-1:0] analog;
		logic [2:0] internal;
		logic [7:0] control;
	} sample_s;

	typedef struct packed {
		logic bank_reg;
		logic [`SET_W-1:0] set_main_reg;
		logic [`SET_W-1:0] set_second_reg;
		logic [11:0] ext_cfg_reg;
		logic [2:0] int_mask_reg;
		logic [2:0] int_edge_reg;
		logic [7:0] ctl_mask_reg;
		logic [7:0] ctl_edge_reg;
		logic [`POST_W-1:0] post_reg;
		rec_e rec_reg;
		logic [10:0] prev_reg;
		logic [`DIV_W-1:0] div_reg;
		logic [`PTR_W-1:0] wptr_reg;
		logic [`PTR_W-1:0] rptr_reg;
		logic [`POSTCNT_W-1:0] post_cnt_reg;
		logic [1:0] wsel_reg;
		logic [31:0] prdata_reg;
		logic clr_ind_reg;
		logic clr_out_reg;
		logic clr_all_reg;
		logic [`REC_DEPTH-1:0][$bits(sample_s)-1:0] mem_reg;
	} state_s;

endpackage : relay_ctl_pkg

// File: hw/relay_ctl.sv
// Purpose: setting-bank selection, reset matrix and disturbance recorder control
// Assumes: all inputs synchronous to pclk; APB slave with zero wait states
// Notes: record storage is flip-flops, one sample per word slot of the buffer
//
// Function
// [RQ1] panel bank value 0 selects main settings, 1 selects second settings
// [RQ2] serial bank-swap command toggles between main and second banks
// [RQ3] external inputs one to three may select the active bank when routed
// [RQ4] with external bank routing, serial and panel bank requests are ignored
// [RQ5] serial reaches both banks; panel reads and writes only the active bank
// [RQ6] reset clears indicators; program adds outputs; both add registers and memory
// [RQ7] external input clears indicators, plus outputs, or everything, per routing
// [RQ8] serial partial reset clears indicators and outputs; full adds registers, memory
// [RQ9] recorder holds six analog and eleven digital channels
// [RQ10] recording memory holds one record of 38 rated cycles
// [RQ11] resetting recorded values empties the recording memory
// [RQ12] recorder samples at forty times rated frequency
// [RQ13] internal stages, blocking, five controls and three intermodule signals trigger
// [RQ14] rising or falling edge of a selected signal starts recording
// [RQ15] serial mask and edge selection for internal trigger signals
// [RQ16] serial mask and edge selection for control trigger signals
// [RQ17] post-trigger cycles follow the setting; remainder is pre-trigger history
// [RQ18] status reads 0 empty, 1 triggered and full; writing 0 empties; the code reads 1 from the trigger on, while post samples are still stored
// [RQ19] triggers ignored while a record is held
// [RQ20] record marker shown while record held and display idle
// [RQ21] stored record is read out through the upload register
// [RQ22] edges found by comparing each sample with the previous one; the code compares with the value of the previous pclk cycle
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "relay_ctl_defines.svh"
module relay_ctl
	import relay_ctl_pkg::*;
#(
	parameter int SAMPLE_DIV = `CLK_HZ / (`SAMPLES_PER_CYCLE * `RATED_HZ)
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// front panel
	input wire logic btn_reset,
	input wire logic btn_program,
	input wire logic panel_bank_wr,
	input wire logic panel_bank_val,
	input wire logic panel_set_wr,
	input wire logic [`SET_W-1:0] panel_set_data,
	output logic [`SET_W-1:0] panel_set_rdata,
	input wire logic display_busy,
	output logic record_marker,
	// control and protection signals
	input wire logic [4:0] external_control_inputs,
	input wire logic [2:0] intermodule_block_signals,
	input wire logic stab_operate,
	input wire logic inst_operate,
	input wire logic harm_block,
	input wire logic [5:0][`ADC_W-1:0] analog_in,
	// results
	output logic active_bank,
	output logic [`SET_W-1:0] active_setting,
	output logic clr_indicators,
	output logic clr_latched,
	output logic clr_registers
);

	localparam logic [`DIV_W-1:0] DIV_LAST = `DIV_W'(SAMPLE_DIV - 1);
	localparam logic [`PTR_W-1:0] PTR_LAST = `PTR_W'(`REC_DEPTH - 1);

	state_s s_reg;
	state_s s_next;

	sample_s smp;
	logic [10:0] dig_now;
	logic wr_acc;
	logic rd_setup;
	logic mapped;
	logic sample_tick;
	logic trig_hit;
	logic ext_bank_on;
	logic ser_partial;
	logic ser_full;
	logic [2:0] bs_rise;
	logic do_ind;
	logic do_out;
	logic do_all;
	logic [95:0] up_word;

	function automatic logic [`PTR_W-1:0] ptr_inc(input logic [`PTR_W-1:0] p);
		ptr_inc = (p == PTR_LAST) ? '0 : p + `PTR_W'(1);
	endfunction : ptr_inc

	// rising edge wanted where edge bit is 0, falling where it is 1
	function automatic logic edge_hit(input logic [7:0] cur, input logic [7:0] prev,
		input logic [7:0] mask, input logic [7:0] fall);
		logic [7:0] r;
		logic [7:0] f;
		r = cur & ~prev;
		f = ~cur & prev;
		edge_hit = |(mask & ((r & ~fall) | (f & fall)));
	endfunction : edge_hit

	function automatic logic addr_mapped(input logic [`ADDR_W-1:0] a);
		case (a)
			`A_BANK, `A_SWAP, `A_EXT_CFG, `A_SER_RESET, `A_INT_MASK, `A_INT_EDGE,
			`A_CTL_MASK, `A_CTL_EDGE, `A_POST, `A_STATUS, `A_UPLOAD,
			`A_SET_MAIN, `A_SET_SECOND: addr_mapped = 1'b1;
			default: addr_mapped = 1'b0;
		endcase
	endfunction : addr_mapped

	always_comb begin
		smp.analog = analog_in;
		smp.internal = {harm_block, inst_operate, stab_operate};
		smp.control = {intermodule_block_signals, external_control_inputs};
	end

	assign dig_now = {smp.internal, smp.control}; // RQ9
	assign mapped = addr_mapped(paddr);
	assign wr_acc = psel & penable & pwrite & mapped;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign sample_tick = (s_reg.div_reg == DIV_LAST); // RQ12
	assign ext_bank_on = |s_reg.ext_cfg_reg[`F_ROUTE_BANK];
	assign ser_partial = wr_acc & (paddr == `A_SER_RESET) & pwdata[`F_SER_PARTIAL];
	assign ser_full = wr_acc & (paddr == `A_SER_RESET) & pwdata[`F_SER_FULL];
	assign bs_rise = external_control_inputs[2:0] & ~s_reg.prev_reg[2:0];

	// RQ22
	assign trig_hit = edge_hit({5'h00, dig_now[10:8]}, {5'h00, s_reg.prev_reg[10:8]},
		{5'h00, s_reg.int_mask_reg}, {5'h00, s_reg.int_edge_reg}) // RQ13 RQ14 RQ15
		| edge_hit(dig_now[7:0], s_reg.prev_reg[7:0],
		s_reg.ctl_mask_reg, s_reg.ctl_edge_reg); // RQ13 RQ14 RQ16

	// reset matrix: wider scopes always include the narrower ones
	assign do_all = (btn_reset & btn_program) // RQ6
		| (|(bs_rise & s_reg.ext_cfg_reg[`F_ROUTE_ALL])) // RQ7
		| ser_full; // RQ8
	assign do_out = btn_program | do_all // RQ6
		| (|(bs_rise & s_reg.ext_cfg_reg[`F_ROUTE_OUT])) // RQ7
		| ser_partial; // RQ8
	assign do_ind = btn_reset | do_out
		| (|(bs_rise & s_reg.ext_cfg_reg[`F_ROUTE_IND])); // RQ6 RQ7

	assign up_word = 96'(s_reg.mem_reg[s_reg.rptr_reg]);

	always_comb begin
		s_next = s_reg;
		s_next.prev_reg = dig_now;
		s_next.clr_ind_reg = do_ind;
		s_next.clr_out_reg = do_out;
		s_next.clr_all_reg = do_all;
		s_next.div_reg = sample_tick ? '0 : s_reg.div_reg + `DIV_W'(1);

		// bank selection
		if (ext_bank_on) begin
			s_next.bank_reg = |(external_control_inputs[2:0] & s_reg.ext_cfg_reg[`F_ROUTE_BANK]); // RQ3 RQ4
		end else if (wr_acc && paddr == `A_SWAP) begin
			s_next.bank_reg = ~s_reg.bank_reg; // RQ2
		end else if (panel_bank_wr) begin
			s_next.bank_reg = panel_bank_val ? `BANK_SECOND : `BANK_MAIN; // RQ1
		end

		// panel edits touch only the bank in use; serial writes below win on collision
		if (panel_set_wr) begin
			if (s_reg.bank_reg == `BANK_SECOND) begin
				s_next.set_second_reg = panel_set_data; // RQ5
			end else begin
				s_next.set_main_reg = panel_set_data; // RQ5
			end
		end

		if (wr_acc) begin
			case (paddr)
				`A_EXT_CFG: s_next.ext_cfg_reg = pwdata[11:0];
				`A_INT_MASK: s_next.int_mask_reg = pwdata[2:0]; // RQ15
				`A_INT_EDGE: s_next.int_edge_reg = pwdata[2:0]; // RQ15
				`A_CTL_MASK: s_next.ctl_mask_reg = pwdata[7:0]; // RQ16
				`A_CTL_EDGE: s_next.ctl_edge_reg = pwdata[7:0]; // RQ16
				`A_POST: s_next.post_reg = pwdata[`POST_W-1:0]; // RQ17
				`A_SET_MAIN: s_next.set_main_reg = pwdata[`SET_W-1:0]; // RQ5
				`A_SET_SECOND: s_next.set_second_reg = pwdata[`SET_W-1:0]; // RQ5
				default: ;
			endcase
		end

		// recorder
		case (s_reg.rec_reg)
			REC_ARMED: begin
				if (sample_tick) begin
					s_next.mem_reg[s_reg.wptr_reg] = smp; // RQ10
					s_next.wptr_reg = ptr_inc(s_reg.wptr_reg);
				end
				if (trig_hit) begin
					s_next.rec_reg = REC_POST; // RQ14
					s_next.post_cnt_reg = `POSTCNT_W'(s_reg.post_reg) *
						`POSTCNT_W'(`SAMPLES_PER_CYCLE); // RQ17
				end
			end
			REC_POST: begin
				if (sample_tick) begin
					if (s_reg.post_cnt_reg == '0) begin
						s_next.rec_reg = REC_FULL;
						s_next.rptr_reg = s_reg.wptr_reg;
						s_next.wsel_reg = '0;
					end else begin
						s_next.mem_reg[s_reg.wptr_reg] = smp; // RQ17
						s_next.wptr_reg = ptr_inc(s_reg.wptr_reg);
						s_next.post_cnt_reg = s_reg.post_cnt_reg - `POSTCNT_W'(1);
					end
				end
			end
			REC_FULL: ; // RQ19
			default: s_next.rec_reg = REC_ARMED;
		endcase

		// upload walks oldest to newest, three words per sample
		if (psel && penable && !pwrite && paddr == `A_UPLOAD && s_reg.rec_reg == REC_FULL) begin
			if (s_reg.wsel_reg == `WORDS_PER_SAMPLE - 2'h1) begin
				s_next.wsel_reg = '0;
				s_next.rptr_reg = ptr_inc(s_reg.rptr_reg); // RQ21
			end else begin
				s_next.wsel_reg = s_reg.wsel_reg + 2'h1; // RQ21
			end
		end

		// emptying outranks a trigger in the same cycle
		if (do_all || (wr_acc && paddr == `A_STATUS && !pwdata[0])) begin
			s_next.rec_reg = REC_ARMED; // RQ11 RQ18
			s_next.wptr_reg = '0;
			s_next.rptr_reg = '0;
			s_next.wsel_reg = '0;
		end

		// read data latched in setup so it stands through the access phase
		if (rd_setup) begin
			case (paddr)
				`A_BANK: s_next.prdata_reg = {31'h0, s_reg.bank_reg};
				`A_EXT_CFG: s_next.prdata_reg = {20'h0, s_reg.ext_cfg_reg};
				`A_INT_MASK: s_next.prdata_reg = {29'h0, s_reg.int_mask_reg};
				`A_INT_EDGE: s_next.prdata_reg = {29'h0, s_reg.int_edge_reg};
				`A_CTL_MASK: s_next.prdata_reg = {24'h0, s_reg.ctl_mask_reg};
				`A_CTL_EDGE: s_next.prdata_reg = {24'h0, s_reg.ctl_edge_reg};
				`A_POST: s_next.prdata_reg = {26'h0, s_reg.post_reg};
				`A_STATUS: s_next.prdata_reg = {31'h0, s_reg.rec_reg != REC_ARMED}; // RQ18
				`A_UPLOAD: begin
					case (s_reg.wsel_reg)
						2'h0: s_next.prdata_reg = up_word[31:0];
						2'h1: s_next.prdata_reg = up_word[63:32];
						default: s_next.prdata_reg = up_word[95:64];
					endcase
				end
				`A_SET_MAIN: s_next.prdata_reg = {16'h0, s_reg.set_main_reg};
				`A_SET_SECOND: s_next.prdata_reg = {16'h0, s_reg.set_second_reg};
				default: s_next.prdata_reg = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata_reg;
	assign active_bank = s_reg.bank_reg; // RQ1
	assign active_setting = s_reg.bank_reg ? s_reg.set_second_reg : s_reg.set_main_reg;
	assign panel_set_rdata = active_setting; // RQ5
	assign record_marker = (s_reg.rec_reg == REC_FULL) & ~display_busy; // RQ20
	assign clr_indicators = s_reg.clr_ind_reg;
	assign clr_latched = s_reg.clr_out_reg;
	assign clr_registers = s_reg.clr_all_reg;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_swap_toggles: assert property ((wr_acc && paddr == `A_SWAP && !ext_bank_on)
		|=> active_bank != $past(active_bank)) else $error("bank swap missed"); // RQ2
	a_ext_bank_lock: assert property ((ext_bank_on && $past(ext_bank_on) && panel_bank_wr)
		|=> active_bank == |($past(external_control_inputs[2:0])
		& $past(s_reg.ext_cfg_reg[`F_ROUTE_BANK])))
		else $error("bank not held by external input"); // RQ4
	a_panel_bank: assert property ((!ext_bank_on && !(wr_acc && paddr == `A_SWAP) && panel_bank_wr)
		|=> active_bank == $past(panel_bank_val)) else $error("panel bank value ignored"); // RQ1
	a_reset_both: assert property ((btn_reset && btn_program)
		|=> clr_indicators && clr_latched && clr_registers) else $error("full reset missing"); // RQ6
	a_reset_only: assert property ((btn_reset && !btn_program && !ser_partial && !ser_full
		&& !(|bs_rise)) |=> clr_indicators && !clr_latched && !clr_registers)
		else $error("reset scope wrong"); // RQ6
	a_ser_partial: assert property ((ser_partial && !ser_full && !btn_program && !(|bs_rise))
		|=> clr_latched && !clr_registers) else $error("partial reset scope wrong"); // RQ8
	a_empty_on_clear: assert property (do_all |=> s_reg.rec_reg == REC_ARMED)
		else $error("memory not emptied"); // RQ11
	a_full_holds: assert property ((s_reg.rec_reg == REC_FULL && !do_all
		&& !(wr_acc && paddr == `A_STATUS)) |=> s_reg.rec_reg == REC_FULL)
		else $error("record lost without empty"); // RQ19
	a_trig_starts: assert property ((s_reg.rec_reg == REC_ARMED && trig_hit && !do_all
		&& !(wr_acc && paddr == `A_STATUS && !pwdata[0])) |=> s_reg.rec_reg == REC_POST)
		else $error("trigger missed"); // RQ14
	a_marker: assert property ((s_reg.rec_reg == REC_POST && sample_tick
		&& s_reg.post_cnt_reg == '0 && !do_all
		&& !(wr_acc && paddr == `A_STATUS && !pwdata[0]))
		|=> record_marker || display_busy) else $error("marker missing"); // RQ20
	a_tick_period: assert property (sample_tick |=> !sample_tick)
		else $error("sample tick too dense"); // RQ12

	c_trigger: cover property (s_reg.rec_reg == REC_ARMED ##1 s_reg.rec_reg == REC_POST);
	c_full: cover property (s_reg.rec_reg == REC_POST ##1 s_reg.rec_reg == REC_FULL);
	c_upload: cover property (psel && penable && paddr == `A_UPLOAD && s_reg.rec_reg == REC_FULL);
	c_full_reset: cover property (btn_reset && btn_program);

endmodule : relay_ctl

// File: tb/field_model.sv
// Purpose: front panel and field signal model facing the relay control block
// Assumes: every change lands by non-blocking assignment just after a pclk rising edge
// Notes: buttons and panel writes are single-cycle pulses, as a real panel scan gives
`timescale 1ns/1ps
module field_model (
	// clock
	input wire logic pclk,
	// field signals
	output logic [4:0] ext,
	output logic [2:0] intm,
	output logic [2:0] prot,
	// panel
	output logic btn_r,
	output logic btn_p,
	output logic bank_wr,
	output logic bank_val,
	output logic set_wr,
	output logic [15:0] set_data
);
	initial begin
		{ext, intm, prot, btn_r, btn_p, bank_wr, bank_val, set_wr, set_data} = '0;
	end
	task automatic sig(input logic [7:0] c, input logic [2:0] p);
		@(posedge pclk);
		{intm, ext} <= c;
		prot <= p;
	endtask : sig
	// a held button would repeat the clear every cycle, so release after one
	task automatic press(input logic r, input logic p);
		@(posedge pclk);
		btn_r <= r;
		btn_p <= p;
		@(posedge pclk);
		btn_r <= 1'h0;
		btn_p <= 1'h0;
	endtask : press
	task automatic panel(input logic bw, input logic bv, input logic sw, input logic [15:0] d);
		@(posedge pclk);
		bank_wr <= bw;
		bank_val <= bv;
		set_wr <= sw;
		set_data <= d;
		@(posedge pclk);
		bank_wr <= 1'h0;
		set_wr <= 1'h0;
	endtask : panel
endmodule : field_model

// File: tb/tb.sv
// Purpose: self-checking bench of the relay control block
// Assumes: SAMPLE_DIV shortened to 4 so a full record fits in a short run
// Notes: analog inputs stay constant so uploaded samples are predictable
`timescale 1ns/1ps
`include "relay_ctl_defines.svh"
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, display_busy;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [5:0][11:0] ana;
	logic [4:0] ext;
	logic [2:0] intm, prot, acc;
	logic btn_r, btn_p, bank_wr, bank_val, set_wr, marker, bank, ci, cl, cr, e;
	logic [15:0] set_data, pset, aset, m, s, v;
	logic [95:0] exp_s;
	int bad_count, total_checks;
	relay_ctl #(.SAMPLE_DIV(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .btn_reset(btn_r), .btn_program(btn_p),
		.panel_bank_wr(bank_wr), .panel_bank_val(bank_val), .panel_set_wr(set_wr),
		.panel_set_data(set_data), .panel_set_rdata(pset), .display_busy(display_busy),
		.record_marker(marker), .external_control_inputs(ext),
		.intermodule_block_signals(intm), .stab_operate(prot[0]), .inst_operate(prot[1]),
		.harm_block(prot[2]), .analog_in(ana), .active_bank(bank), .active_setting(aset),
		.clr_indicators(ci), .clr_latched(cl), .clr_registers(cr));
	field_model field_u (.pclk(pclk), .ext(ext), .intm(intm), .prot(prot), .btn_r(btn_r),
		.btn_p(btn_p), .bank_wr(bank_wr), .bank_val(bank_val), .set_wr(set_wr),
		.set_data(set_data));
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] ex);
		total_checks++;
		if (got !== ex) begin
			bad_count++;
			$display("ERROR t=%0t got %h expected %h", $time, got, ex);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
		apb(1'h0, a, 32'h0);
		chk(r & mk, ex & mk);
	endtask : rd
	// clear pulses may land a cycle or two after the cause, so gather a short window
	task automatic watch();
		acc = 3'h0;
		repeat (4) begin
			#1 acc = acc | {cr, cl, ci};
			@(posedge pclk);
		end
	endtask : watch
	function automatic logic [31:0] clr_exp(input int scope);
		return (scope == 0) ? 32'h1 : (scope == 1) ? 32'h3 : 32'h7;
	endfunction : clr_exp
	initial begin
		#200000;
		bad_count++;
		$display("ERROR t=%0t watchdog expired", $time);
		complete_run();
	end
	initial begin
		int j;
		void'($urandom(95662));
		{psel, penable, pwrite, paddr, pwdata, display_busy} = '0;
		presetn = 1'h0;
		for (j = 0; j < 6; j++) ana[j] = 12'($urandom);
		m = 16'($urandom);
		s = 16'($urandom);
		v = 16'($urandom);
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		rd(`A_BANK, 32'h0, 32'h1);
		rd(`A_STATUS, 32'h0, 32'h1);
		$display("test reset done");
		wr(`A_SET_MAIN, {16'h0, m});
		wr(`A_SET_SECOND, {16'h0, s});
		#1 chk({16'h0, pset}, {16'h0, m});
		field_u.panel(1'h1, 1'h1, 1'h0, 16'h0);
		#1 chk({15'h0, bank, aset}, {15'h0, 1'h1, s});
		field_u.panel(1'h0, 1'h0, 1'h1, v);
		rd(`A_SET_SECOND, {16'h0, v}, 32'hFFFF);
		rd(`A_SET_MAIN, {16'h0, m}, 32'hFFFF);
		wr(`A_SWAP, 32'h0);
		#1 chk({15'h0, bank, aset}, {16'h0, m});
		rd(8'hFC, 32'h0, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("test banks done");
		wr(`A_EXT_CFG, 32'h200);
		field_u.sig(8'h01, 3'h0);
		repeat (3) @(posedge pclk);
		#1 chk({31'h0, bank}, 32'h1);
		wr(`A_SWAP, 32'h0);
		field_u.panel(1'h1, 1'h0, 1'h0, 16'h0);
		#1 chk({31'h0, bank}, 32'h1);
		field_u.sig(8'h00, 3'h0);
		wr(`A_EXT_CFG, 32'h0);
		$display("test external bank done");
		for (j = 0; j < 3; j++) begin
			field_u.press(j != 1, j != 0);
			watch();
			chk({29'h0, acc}, clr_exp(j));
		end
		for (j = 0; j < 3; j++) begin
			int k;
			k = $urandom % 3;
			wr(`A_EXT_CFG, 32'h1 << (3 * j + k));
			field_u.sig(8'(1 << k), 3'h0);
			watch();
			chk({29'h0, acc}, clr_exp(j));
			field_u.sig(8'h00, 3'h0);
		end
		wr(`A_EXT_CFG, 32'h0);
		wr(`A_SER_RESET, 32'h1);
		watch();
		chk({29'h0, acc}, clr_exp(1));
		wr(`A_SER_RESET, 32'h2);
		watch();
		chk({29'h0, acc}, clr_exp(2));
		$display("test reset matrix done");
		wr(`A_INT_MASK, 32'h1);
		wr(`A_INT_EDGE, 32'h1);
		wr(`A_POST, 32'h1);
		field_u.sig(8'h00, 3'h1);
		repeat (20) @(posedge pclk);
		rd(`A_STATUS, 32'h0, 32'h1);
		field_u.sig(8'h00, 3'h0);
		repeat (20) @(posedge pclk);
		rd(`A_STATUS, 32'h1, 32'h1);
		#1 chk({31'h0, marker}, 32'h0);
		// one post cycle is forty ticks of four clocks: full lands 161 to 164 clocks after trigger
		repeat (128) @(posedge pclk);
		#1 chk({31'h0, marker}, 32'h0);
		repeat (20) @(posedge pclk);
		#1 chk({31'h0, marker}, 32'h1);
		@(posedge pclk);
		display_busy <= 1'h1;
		#1 chk({31'h0, marker}, 32'h0);
		@(posedge pclk);
		display_busy <= 1'h0;
		wr(`A_STATUS, 32'h0);
		rd(`A_STATUS, 32'h0, 32'h1);
		field_u.sig(8'h00, 3'h1);
		field_u.sig(8'h00, 3'h0);
		repeat (20) @(posedge pclk);
		rd(`A_STATUS, 32'h1, 32'h1);
		wr(`A_SER_RESET, 32'h2);
		rd(`A_STATUS, 32'h0, 32'h1);
		wr(`A_INT_EDGE, 32'h0);
		$display("test falling trigger done");
		for (j = 0; j < 11; j++) begin
			wr(`A_STATUS, 32'h0);
			wr(`A_INT_MASK, (j < 3) ? (32'h1 << j) : 32'h0);
			wr(`A_CTL_MASK, (j < 3) ? 32'h0 : (32'h1 << (j - 3)));
			field_u.sig((j < 3) ? 8'h0 : 8'(1 << (j - 3)), (j < 3) ? 3'(1 << j) : 3'h0);
			repeat (12) @(posedge pclk);
			rd(`A_STATUS, 32'h1, 32'h1);
			field_u.sig(8'h00, 3'h0);
			repeat (12) @(posedge pclk);
		end
		wr(`A_STATUS, 32'h0);
		wr(`A_INT_MASK, 32'h0);
		wr(`A_CTL_MASK, 32'hFE);
		field_u.sig(8'h01, 3'h0);
		repeat (12) @(posedge pclk);
		rd(`A_STATUS, 32'h0, 32'h1);
		field_u.sig(8'h00, 3'h0);
		$display("test trigger sources done");
		wr(`A_CTL_MASK, 32'h1);
		wr(`A_POST, 32'd38);
		field_u.sig(8'h01, 3'h0);
		repeat (12) @(posedge pclk);
		rd(`A_STATUS, 32'h1, 32'h1);
		repeat (38 * 40 * 4 + 200) @(posedge pclk);
		// every stored sample is post-trigger, with only control input one high
		exp_s = {13'h0, ana, 11'h001};
		for (j = 0; j < 6; j++) begin
			rd(`A_UPLOAD, exp_s[32 * (j % 3) +: 32], 32'hFFFFFFFF);
		end
		$display("test upload done");
		complete_run();
	end
endmodule : tb
